// ### bench/lp_filter_model.sv
`timescale 1ns/1ns
`default_nettype none
module lp_filter_model (
    // Pin side.
    input  wire logic  hclk,
    input  wire logic  pin,
    input  wire logic  pin_en,
    // Integrated low time.
    output logic [15:0] low_count
);
    logic level;
    assign level = pin_en ? pin : 1'bz;
    initial low_count = 16'h0;
    // Only a driven low charges the filter; a floating pin counts as nothing.
    always @(posedge hclk) begin
        if (level === 1'b0) low_count <= low_count + 16'h1;
    end
endmodule
`default_nettype wire

// ### bench/timer_pulse_generator_pwm_test.sv
`include "tpg_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module timer_pulse_generator_pwm_test;
    import tpg_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    ahb_req_type ahb_req = '0;
    ahb_rsp_type ahb_rsp;
    logic        pin, pin_en, irq_set;
    logic [15:0] low_count;
    int          n_errors = 0;
    int          n_compared = 0;
    always #50 hclk = ~hclk;
    initial ahb_req.hready = 1'b1;
    timer_pulse_generator_pwm u_timer_pulse_generator_pwm (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .pulse_out_pin(pin), .pulse_out_pin_en(pin_en), .pulse_gen_irq_set(irq_set));
    lp_filter_model u_lp_filter_model (.hclk(hclk), .pin(pin), .pin_en(pin_en), .low_count(low_count));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        ahb_req.hsel <= 1'b1;
        ahb_req.htrans <= 2'h2;
        ahb_req.haddr <= {24'h0, a};
        ahb_req.hwrite <= w;
        ahb_req.hsize <= 3'h2;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        ahb_req.hsel <= 1'b0;
        ahb_req.htrans <= 2'h0;
        ahb_req.hwdata <= d;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        q = ahb_rsp.hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (irq_set !== 1'b1);
    endtask
    task automatic pin_is(input logic [7:0] mode, input logic [1:0] exp);
        wr(`TPG_OFS_MODE, mode);
        repeat (2) @(posedge hclk);
        check({pin_en, pin & pin_en}, exp);
    endtask
    task automatic t_regs;
        rd(`TPG_OFS_MODULO_HIGH, 32'h0);
        wr(`TPG_OFS_MODULO_LOW, 8'hff);
        rd(`TPG_OFS_MODULO_LOW, 32'hfc);
        wr(`TPG_OFS_MODE, 8'h44);
        rd(`TPG_OFS_MODE, 32'h0);
        wr(8'h10, 8'hff);
        rd(8'h10, 32'h0);
    endtask
    task automatic t_timer;
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(`TPG_OFS_MODULO_HIGH, 8'h02);
            wr(`TPG_OFS_MODULO_LOW, 8'h04 << i);
            wr(`TPG_OFS_MODE, 8'ha9);
            wr(`TPG_OFS_MODE, 8'hab);
            wait_irq(n);
            wait_irq(n);
            check(n, (256 >> i) * 3);
            wr(`TPG_OFS_MODE, 8'ha9);
        end
    endtask
    // One latch value only: each sub-period costs 32768 cycles of run time.
    task automatic t_pwm;
        int n;
        logic [15:0] c0, dl;
        wr(`TPG_OFS_MODULO_HIGH, 8'h81);
        wr(`TPG_OFS_MODULO_LOW, 8'h54);
        wr(`TPG_OFS_MODE, 8'ha8);
        wr(`TPG_OFS_MODE, 8'haa);
        wait_irq(n);
        c0 = low_count;
        wait_irq(n);
        dl = low_count - c0;
        check(n, 32'h8000);
        check(dl, 16'h40aa);
        wr(`TPG_OFS_MODE, 8'ha8);
        rd(`TPG_OFS_STAT, 32'h1);
        wr(`TPG_OFS_STAT, 8'h01);
        rd(`TPG_OFS_STAT, 32'h0);
    endtask
    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        pin_is(8'h90, 2'h3);
        pin_is(8'h80, 2'h2);
        pin_is(8'h10, 2'h0);
        t_timer;
        t_pwm;
        report_and_stop;
    end
    initial begin
        #9000000;
        n_errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire

// ### bench/tpg_props.sv
`include "tpg_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tpg_props #(
    parameter int SUB_BITS = 15
) (
    // Watched ports.
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire tpg_pkg::ahb_req_type ahb_req,
    input wire tpg_pkg::ahb_rsp_type ahb_rsp,
    input wire logic                 pulse_out_pin,
    input wire logic                 pulse_out_pin_en,
    input wire logic                 pulse_gen_irq_set
);
    import tpg_pkg::*;
    logic        wr_ff, rd_ff, seen_ff, wr_mode;
    logic [7:0]  adr_ff, mode_ff;
    logic [16:0] gap_ff;
    assign wr_mode = wr_ff && adr_ff == `TPG_OFS_MODE;
    // A mode write restarts the gap count and clears seen_ff, so a run start never looks late.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_ff, rd_ff, seen_ff, adr_ff, mode_ff, gap_ff} <= '0;
        end else begin
            wr_ff <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite;
            rd_ff <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && !ahb_req.hwrite;
            adr_ff <= ahb_req.haddr[7:0];
            mode_ff <= wr_mode ? ahb_req.hwdata[7:0] : mode_ff;
            gap_ff <= (wr_mode || pulse_gen_irq_set) ? 17'h0 : gap_ff + 17'h1;
            seen_ff <= !wr_mode && (seen_ff || pulse_gen_irq_set);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; ahb_rsp.hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_okay; !ahb_rsp.hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus error response");
    property p_idle; !rd_ff |-> ahb_rsp.hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside data phase");
    property p_low_bits; rd_ff && adr_ff == `TPG_OFS_MODULO_LOW |-> ahb_rsp.hrdata[1:0] == 2'h0; endproperty
    a_low_bits: assert property (p_low_bits) else $error("low modulo bits not zero");
    property p_pin_en; wr_mode |-> ##2 pulse_out_pin_en == $past(ahb_req.hwdata[7], 2); endproperty
    a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
    property p_static;
        wr_mode && ahb_req.hwdata[7] && !ahb_req.hwdata[5] |-> ##2 pulse_out_pin == $past(ahb_req.hwdata[4], 2);
    endproperty
    a_static: assert property (p_static) else $error("static level wrong");
    property p_irq_pulse; pulse_gen_irq_set |=> !pulse_gen_irq_set [*8]; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt set too long");
    property p_irq_gap;
        pulse_gen_irq_set && seen_ff && !mode_ff[0] |-> gap_ff == 17'(2 ** SUB_BITS - 1);
    endproperty
    a_irq_gap: assert property (p_irq_gap) else $error("pulse interrupt interval wrong");
    property p_stopped; !mode_ff[1] [*2] |-> !pulse_gen_irq_set; endproperty
    a_stopped: assert property (p_stopped) else $error("interrupt while stopped");
endmodule
bind timer_pulse_generator_pwm tpg_props #(.SUB_BITS(SUB_BITS)) u_tpg_props (.hclk(hclk), .hresetn(hresetn),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .pulse_out_pin(pulse_out_pin), .pulse_out_pin_en(pulse_out_pin_en),
    .pulse_gen_irq_set(pulse_gen_irq_set));
`default_nettype wire

// ### verilog/timer_pulse_generator_pwm.sv
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`include "tpg_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module timer_pulse_generator_pwm #(
    parameter int SUB_BITS  = `TPG_SUB_BITS,
    parameter int FUND_BITS = `TPG_FUND_BITS
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Register bus
    input  wire tpg_pkg::ahb_req_type ahb_req,
    output var  tpg_pkg::ahb_rsp_type ahb_rsp,
    // Output pin
    output logic                      pulse_out_pin,
    output logic                      pulse_out_pin_en,
    // Interrupt request set pulse
    output logic                      pulse_gen_irq_set
);
    import tpg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // The spreading of the fine bits is wired for these two period lengths only.
    if (SUB_BITS != `TPG_SUB_BITS || FUND_BITS != `TPG_FUND_BITS) begin : g_bad_period
        $error("Period widths other than 15 and 10 bits are not supported.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half-prescale tick: the square wave toggles every half period so that its
    // full period equals the interrupt interval.
    function automatic logic half_tick(input logic [7:0] pre, input logic [4:0] sel);
        logic t;
        t = 1'b0;
        case (sel)
            5'h01:   t = (pre[6:0] == 7'h7f);
            5'h02:   t = (pre[5:0] == 6'h3f);
            5'h04:   t = (pre[4:0] == 5'h1f);
            5'h08:   t = (pre[3:0] == 4'hf);
            5'h10:   t = (pre[2:0] == 3'h7);
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic [31:0] read_reg(input logic [7:0] adr, input state_type s);
        logic [31:0] d;
        d = 32'h0;
        case (adr)
            `TPG_OFS_MODE: d = {24'h0, s.mode};
            `TPG_OFS_MODULO_LOW: d = {24'h0, s.mod_lo[7:2], 2'b00};
            `TPG_OFS_MODULO_HIGH: d = {24'h0, s.mod_hi};
            `TPG_OFS_STAT: d = {31'h0, s.irq_flag};
            default:       d = 32'h0;
        endcase
        return d;
    endfunction

    // Active-low pulse level for one position of the sub-period.
    function automatic logic pwm_level(input logic [14:0] cyc, input logic [13:0] val);
        logic [4:0]  k;
        logic        extra;
        logic [10:0] low_len;
        k       = cyc[14:10];
        // Bit-reversed index spreads the fine steps evenly over the sub-period.
        extra   = ({k[0], k[1], k[2], k[3], k[4]} < {val[3:0], 1'b0});
        low_len = {1'b0, val[13:4]} + {10'h0, extra};
        return ~({1'b0, cyc[9:0]} < low_len);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    state_type   st;
    state_type   nx;
    logic        take;
    logic        run;
    logic        timer_mode;
    logic        reload;
    logic [13:0] regs_val;
    logic        pulse_level;

    always_comb begin
        nx          = st;
        nx.irq_set  = 1'b0;
        take        = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        run         = st.mode[`TPG_RUN_BIT];
        timer_mode  = st.mode[`TPG_OP_MODE_BIT];
        reload      = st.mode[`TPG_RELOAD_BIT];
        regs_val    = {st.mod_hi, st.mod_lo[7:2]};
        pulse_level = 1'b1;

        // Data phase of a write.
        if (st.dph_wr) begin
            case (st.dph_adr)
                `TPG_OFS_MODE: nx.mode = ahb_req.hwdata[7:0] & `TPG_MODE_WMASK;
                `TPG_OFS_MODULO_LOW: nx.mod_lo = ahb_req.hwdata[7:0];
                `TPG_OFS_MODULO_HIGH: nx.mod_hi = ahb_req.hwdata[7:0];
                `TPG_OFS_STAT: begin
                    if (ahb_req.hwdata[`TPG_IRQ_FLAG_BIT]) begin
                        nx.irq_flag = 1'b0;
                    end
                end
                default: nx.irq_flag = nx.irq_flag;
            endcase
        end

        // Engine; a flag set below overrides a clear made above.
        if (!run) begin
            nx.cyc  = 15'h0;
            nx.pre  = 8'h0;
            nx.cnt  = 8'h0;
            nx.tff  = 1'b0;
            if (reload) begin
                nx.latch = regs_val;
            end
            nx.work = nx.latch;
        end else if (timer_mode) begin
            nx.pre = st.pre + 8'h1;
            if (half_tick(st.pre, st.latch[4:0])) begin
                if (st.cnt == st.latch[13:6]) begin
                    nx.cnt = 8'h0;
                    nx.tff = ~st.tff;
                    if (!st.tff) begin
                        nx.irq_flag = 1'b1;
                        nx.irq_set  = 1'b1;
                    end
                    if (reload && st.tff) begin
                        nx.latch = regs_val;
                    end
                end else begin
                    nx.cnt = st.cnt + 8'h1;
                end
            end
        end else begin
            nx.cyc = st.cyc + 15'h1;
            if (nx.cyc[9:0] == 10'h0) begin
                if (reload) begin
                    nx.latch = regs_val;
                end
                nx.work = nx.latch;
            end
            if (nx.cyc == 15'h0) begin
                nx.irq_flag = 1'b1;
                nx.irq_set  = 1'b1;
            end
            pulse_level = pwm_level(nx.cyc, nx.work);
        end

        // Pin selection; the pad is released whenever the enable bit is low.
        nx.pin_en = nx.mode[`TPG_PIN_EN_BIT];
        if (nx.mode[`TPG_PSEL_BIT]) begin
            nx.pin = timer_mode ? nx.tff : pulse_level;
        end else begin
            nx.pin = nx.mode[`TPG_STATIC_BIT];
        end

        // Address phase; reads see writes that finish in this same cycle.
        nx.dph_wr  = take & ahb_req.hwrite;
        nx.dph_adr = ahb_req.haddr[7:0];
        nx.rdata   = (take & ~ahb_req.hwrite) ? read_reg(ahb_req.haddr[7:0], nx) : 32'h0;
        nx.rdy     = 1'b1;
        nx.resp    = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.mode     <= `TPG_MODE_RST;
            st.mod_lo   <= `TPG_MODULO_LOW_RST;
            st.mod_hi   <= `TPG_MODULO_HIGH_RST;
            st.pin      <= 1'b0;
            st.rdy      <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign ahb_rsp.hrdata    = st.rdata;
    assign ahb_rsp.hreadyout = st.rdy;
    assign ahb_rsp.hresp     = st.resp;
    assign pulse_out_pin     = st.pin;
    assign pulse_out_pin_en  = st.pin_en;
    assign pulse_gen_irq_set = st.irq_set;

endmodule

`default_nettype wire

// ### verilog/tpg_defs.svh
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// Register byte offsets on the bus.
`define TPG_OFS_MODE      8'h00
`define TPG_OFS_MODULO_LOW      8'h04
`define TPG_OFS_MODULO_HIGH      8'h08
`define TPG_OFS_STAT      8'h0c

// Mode register bit positions.
`define TPG_OP_MODE_BIT   0
`define TPG_RUN_BIT       1
`define TPG_RELOAD_BIT    3
`define TPG_STATIC_BIT    4
`define TPG_PSEL_BIT      5
`define TPG_PIN_EN_BIT    7
`define TPG_MODE_WMASK    8'hbb

// Status register bit positions.
`define TPG_IRQ_FLAG_BIT  0

// Reset values.
`define TPG_MODE_RST      8'h00
`define TPG_MODULO_LOW_RST      8'h00
`define TPG_MODULO_HIGH_RST      8'h00

// Timing: system clock rate in Hz, period and latch widths in bits.
`define TPG_FX_HZ         10000000
`define TPG_FUND_BITS     10
`define TPG_SUB_BITS      15
`define TPG_LATCH_W       14

`endif

// ### verilog/tpg_pkg.sv
package tpg_pkg;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ahb_rsp_type;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  mod_lo;
        logic [7:0]  mod_hi;
        logic [13:0] latch;
        logic [13:0] work;
        logic [14:0] cyc;
        logic [7:0]  pre;
        logic [7:0]  cnt;
        logic        tff;
        logic        irq_flag;
        logic        irq_set;
        logic        pin;
        logic        pin_en;
        logic        dph_wr;
        logic [7:0]  dph_adr;
        logic [31:0] rdata;
        logic        rdy;
        logic        resp;
    } state_type;

endpackage
